// File: hw/vscfg_regs.sv
`timescale 1ns/1ps
`include "vscfg_consts.svh"
module vscfg_regs
    import vscfg_pkg::*;
#(
    parameter int PULSE_CYC = `VSCFG_PULSE_CYC // termination pulse length in clocks
)(
    input  wire logic         ref_clk,     // 40 MHz clock
    input  wire logic         reset,       // synchronous, active high
    input  wire vscfg_strap_s strap_pins,  // raw strap pins, asynchronous
    input  wire logic         reg_wr,      // write strobe from serial interface
    input  wire logic         reg_rd,      // read strobe from serial interface
    input  wire logic [7:0]   reg_addr,    // register byte offset
    input  wire logic [7:0]   reg_wdata,   // write data
    output logic [7:0]        reg_rdata,   // read data
    output logic              reg_rvalid,  // read data valid pulse
    output logic              parallel_mode, // straps in control
    output vscfg_cfg_s        cfg_out      // configuration to analog cores
);
    localparam int CW = $clog2(PULSE_CYC + 1); // pulse counter width

    vscfg_strap_s   strap_meta_ff;    // first synchroniser stage
    vscfg_strap_s   strap_sync_ff;    // second synchroniser stage
    logic           parallel_ff;      // strap mode active
    vscfg_byte_t    regs_ff [8];      // register contents
    vscfg_byte_t    strap_val [8];    // strap-derived contents
    vscfg_byte_t    nxt_regs [8];     // next register contents
    logic [7:0]     off_tab [8];      // offsets per index
    logic [7:0]     msk_tab [8];      // writable masks per index
    logic [7:0]     rst_tab [8];      // reset values per index
    logic [7:0]     rdata_ff;         // read data register
    logic           rvalid_ff;        // read valid register
    logic [1:0]     hs_route_ff;      // applied highspeed route
    logic [1:0]     aux_route_ff;     // applied aux route
    logic [CW-1:0]  pulse_cnt_ff;     // remaining pulse clocks
    vscfg_cfg_s     cfg_ff;           // output configuration
    logic           access;           // any serial access this cycle
    logic [11:0]    pulse_bits;       // term_pulse_bits
    logic [11:0]    eq_bits;          // equalization_bits

    assign access = reg_wr | reg_rd;
    assign off_tab = '{`VSCFG_OFF_HS_MODES, `VSCFG_OFF_AUX_MODES, `VSCFG_OFF_RX_SET,
                       `VSCFG_OFF_PULSE_AB, `VSCFG_OFF_PULSE_C, `VSCFG_OFF_EQ_AB,
                       `VSCFG_OFF_EQ_C, `VSCFG_OFF_TX_SET};
    assign msk_tab = '{`VSCFG_MSK_MODES, `VSCFG_MSK_MODES, `VSCFG_MSK_RX_SET,
                       `VSCFG_MSK_FULL, `VSCFG_MSK_LOW_NIB, `VSCFG_MSK_FULL,
                       `VSCFG_MSK_LOW_NIB, `VSCFG_MSK_LOW_NIB};
    assign rst_tab = '{`VSCFG_RST_HS_MODES, `VSCFG_RST_AUX_MODES, `VSCFG_RST_RX_SET,
                       `VSCFG_RST_PULSE_AB, `VSCFG_RST_PULSE_C, `VSCFG_RST_EQ_AB,
                       `VSCFG_RST_EQ_C, `VSCFG_RST_TX_SET};

    // straps are board levels, two flops before any use
    always_ff @(posedge ref_clk)
    begin
        strap_meta_ff <= strap_pins;
        strap_sync_ff <= strap_meta_ff;
    end

    // strap image of each register
    always_comb
    begin
        strap_val[0] = {1'b0, strap_sync_ff.hs_enable, 4'h0,
                        strap_sync_ff.source_sel};                      // see (RULE11)
        strap_val[1] = {2'h1, 4'h0, strap_sync_ff.source_sel};          // see (RULE14)
        strap_val[2] = `VSCFG_RST_RX_SET;                               // see (RULE15)
        strap_val[3] = 8'h00;                                           // see (RULE15)
        strap_val[4] = 8'h00;
        strap_val[5] = {8{strap_sync_ff.equal}};                        // see (RULE16)
        strap_val[6] = {4'h0, {4{strap_sync_ff.equal}}};
        strap_val[7] = {4'h0, strap_sync_ff.preemph, 1'b1,
                        strap_sync_ff.current};                         // see (RULE17)
    end

    // straps hold until the first serial access, then stay out until reset
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            parallel_ff <= 1'b1;
        else if (access)
            parallel_ff <= 1'b0; // see (RULE12)
    end

    // in strap mode the registers track the straps, so the first
    // access finds them already latched and a write lands on top
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            nxt_regs[i] = parallel_ff ? strap_val[i] : regs_ff[i]; // see (RULE22)
            if (reg_wr && (reg_addr == off_tab[i]))
                nxt_regs[i] = reg_wdata & msk_tab[i];
        end
    end

    // register storage
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (reset)
                regs_ff[i] <= rst_tab[i];
            else
                regs_ff[i] <= nxt_regs[i];
        end
    end

    // readback one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rvalid_ff <= reg_rd;
            if (reg_rd)
            begin
                rdata_ff <= 8'h00;
                for (int i = 0; i < 8; i++)
                    if (reg_addr == off_tab[i])
                        rdata_ff <= parallel_ff ? strap_val[i] : regs_ff[i];
            end
        end
    end

    // applied routes ignore the illegal code and keep the last good one
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            hs_route_ff  <= 2'h0;
            aux_route_ff <= 2'h0;
        end
        else
        begin
            if (regs_ff[0][1:0] != `VSCFG_ROUTE_ILLEGAL)
                hs_route_ff <= regs_ff[0][1:0];                 // see (RULE19) (RULE21)
            if (regs_ff[1][1:0] != `VSCFG_ROUTE_ILLEGAL)
                aux_route_ff <= regs_ff[1][1:0];                // see (RULE1) (RULE21)
        end
    end

    // pulse window restarts on every highspeed source switch; one shared timer
    // since all flagged channels switch on the same event
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            pulse_cnt_ff <= '0;
        else if ((regs_ff[0][1:0] != `VSCFG_ROUTE_ILLEGAL) &&
                 (regs_ff[0][1:0] != hs_route_ff))
            pulse_cnt_ff <= CW'(PULSE_CYC);                     // see (RULE4)
        else if (pulse_cnt_ff != '0)
            pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
    end

    // bit index follows the channel table: B0-3, A0-3, C3-0
    assign pulse_bits = {regs_ff[4][3:0], regs_ff[3]};          // see (RULE5)
    assign eq_bits    = {regs_ff[6][3:0], regs_ff[5]};          // see (RULE7)

    // output configuration register
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            cfg_ff <= '0;
        else
        begin
            cfg_ff.highspeed_enable     <= regs_ff[0][`VSCFG_BIT_ENABLE]; // see (RULE18)
            cfg_ff.highspeed_source_sel <= hs_route_ff;
            cfg_ff.aux_enable           <= regs_ff[1][`VSCFG_BIT_ENABLE]; // see (RULE20)
            cfg_ff.aux_source_sel       <= aux_route_ff;
            for (int i = 0; i < 12; i++)
                cfg_ff.input_term_connect[i] <= regs_ff[2][`VSCFG_BIT_RX_TERM] &
                    ~(pulse_bits[i] & (pulse_cnt_ff != '0));    // see (RULE2) (RULE3) (RULE4)
            cfg_ff.equalization_bits    <= eq_bits;             // see (RULE6)
            cfg_ff.preemphasis_level    <= regs_ff[7][`VSCFG_BIT_PREEMPHASIS_LEVEL_LO +: 2]; // see (RULE8)
            cfg_ff.output_term_enable   <= regs_ff[7][`VSCFG_BIT_OUTPUT_TERM_ENABLE];  // see (RULE9)
            cfg_ff.output_current_level <= regs_ff[7][`VSCFG_BIT_OUTPUT_CURRENT_LEVEL];  // see (RULE10)
        end
    end

    assign reg_rdata     = rdata_ff;
    assign reg_rvalid    = rvalid_ff;
    assign parallel_mode = parallel_ff;
    assign cfg_out       = cfg_ff;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    strap_mode_ends_a: assert property (access |=> !parallel_ff) // see (RULE12)
        else $error("strap mode survived a serial access");
    strap_mode_stays_a: assert property (!parallel_ff |=> !parallel_ff) // see (RULE12)
        else $error("strap mode returned without reset");
    aux_strap_en_a: assert property (parallel_ff |-> regs_ff[1] == 8'h40 + 8'(strap_val[1][1:0]) ||
        $past(reset)) // see (RULE14)
        else $error("aux enable not one in strap mode");
    hs_route_legal_a: assert property (hs_route_ff != `VSCFG_ROUTE_ILLEGAL) // see (RULE21)
        else $error("illegal highspeed route applied");
    aux_route_hold_a: assert property (regs_ff[1][1:0] == `VSCFG_ROUTE_ILLEGAL
        |=> $stable(aux_route_ff)) // see (RULE21)
        else $error("aux route moved on illegal code");
    term_off_a: assert property (!regs_ff[2][0] |=> cfg_ff.input_term_connect == 12'h000)
        // see (RULE2)
        else $error("termination connected while disabled");
    pulse_start_a: assert property ((regs_ff[0][1:0] != 2'h3) && (regs_ff[0][1:0] != hs_route_ff)
        |=> pulse_cnt_ff == CW'(PULSE_CYC)) // see (RULE4)
        else $error("pulse timer not loaded on switch");
    no_pulse_hold_a: assert property (regs_ff[2][0] && regs_ff[3] == 8'h00 && regs_ff[4] == 8'h00
        |=> cfg_ff.input_term_connect == 12'hFFF) // see (RULE3)
        else $error("unflagged channel disconnected");
    eq_strap_a: assert property (parallel_ff && !access ##1 parallel_ff
        |-> eq_bits == {12{$past(strap_sync_ff.equal)}}) // see (RULE16)
        else $error("equalization bits not from strap");
    tx_out_a: assert property (##1 cfg_ff.preemphasis_level == $past(regs_ff[7][3:2]))
        // see (RULE8)
        else $error("pre-emphasis output mismatch");
endmodule

// File: hw/vscfg_consts.svh
// Function
// (RULE1) aux select codes route sources A, B, C
// (RULE2) input termination enable gates all terminations
// (RULE3) pulse bit zero keeps termination connected
// (RULE4) pulse bit one disconnects 100 ms
// (RULE5) pulse bits map B0-3, A0-3, C3-0
// (RULE6) equalization bit selects 6 or 12 dB
// (RULE7) equalization bits share the pulse mapping
// (RULE8) two-bit pre-emphasis level for all outputs
// (RULE9) output termination bit connects output terminations
// (RULE10) output current bit selects 10 or 20 mA
// (RULE11) parallel mode takes values from strap pins
// (RULE12) straps count until first serial access
// (RULE13) board ties straps high or low
// (RULE14) parallel aux enable one, aux follows straps
// (RULE15) parallel forces termination on, pulses off
// (RULE16) one equalization strap drives all twelve bits
// (RULE17) parallel transmitter bits from pre-emphasis, current straps
// (RULE18) highspeed enable bit selects standby or on
// (RULE19) highspeed select codes route sources A, B, C
// (RULE20) aux enable bit opens or closes switch
// (RULE21) illegal code eleven keeps previous routing
// (RULE22) first access latches strap values into registers
`ifndef VSCFG_CONSTS_SVH
`define VSCFG_CONSTS_SVH
// register byte offsets on the serial register port
`define VSCFG_OFF_HS_MODES   8'h00
`define VSCFG_OFF_AUX_MODES  8'h01
`define VSCFG_OFF_RX_SET     8'h10
`define VSCFG_OFF_PULSE_AB   8'h11
`define VSCFG_OFF_PULSE_C    8'h12
`define VSCFG_OFF_EQ_AB      8'h13
`define VSCFG_OFF_EQ_C       8'h14
`define VSCFG_OFF_TX_SET     8'h20
// reset values
`define VSCFG_RST_HS_MODES   8'h40
`define VSCFG_RST_AUX_MODES  8'h40
`define VSCFG_RST_RX_SET     8'h01
`define VSCFG_RST_PULSE_AB   8'h00
`define VSCFG_RST_PULSE_C    8'h00
`define VSCFG_RST_EQ_AB      8'h00
`define VSCFG_RST_EQ_C       8'h00
`define VSCFG_RST_TX_SET     8'h03
// writable bit masks, reserved bits read zero
`define VSCFG_MSK_MODES      8'h43
`define VSCFG_MSK_RX_SET     8'h01
`define VSCFG_MSK_LOW_NIB    8'h0F
`define VSCFG_MSK_FULL       8'hFF
// field positions
`define VSCFG_BIT_ENABLE     6
`define VSCFG_BIT_RX_TERM    0
`define VSCFG_BIT_OUTPUT_CURRENT_LEVEL     0
`define VSCFG_BIT_OUTPUT_TERM_ENABLE     1
`define VSCFG_BIT_PREEMPHASIS_LEVEL_LO   2
// route code that must never be applied
`define VSCFG_ROUTE_ILLEGAL  2'h3
// termination pulse timing
`define VSCFG_PULSE_MS       100
`define VSCFG_CLK_HZ         40000000
`define VSCFG_PULSE_CYC      ((`VSCFG_PULSE_MS * `VSCFG_CLK_HZ) / 1000)
`endif

// File: hw/vscfg_pkg.sv
package vscfg_pkg;
    // strap pin group, raw at the pins and after synchronisation
    typedef struct packed {
        logic       hs_enable;  // strap_highspeed_enable
        logic [1:0] source_sel; // strap_source_sel
        logic       equal;      // strap_equalization
        logic [1:0] preemph;    // strap_preemphasis_bits
        logic       current;    // strap_output_current
    } vscfg_strap_s;
    // applied switch configuration
    typedef struct packed {
        logic        highspeed_enable;
        logic [1:0]  highspeed_source_sel;
        logic        aux_enable;
        logic [1:0]  aux_source_sel;
        logic [11:0] input_term_connect;
        logic [11:0] equalization_bits;
        logic [1:0]  preemphasis_level;
        logic        output_term_enable;
        logic        output_current_level;
    } vscfg_cfg_s;
    typedef logic [7:0] vscfg_byte_t;
endpackage

// File: sim/vscfg_strap_board.sv
`timescale 1ns/1ps
// board straps: every pin tied solid to a rail, never left floating
module vscfg_strap_board
    import vscfg_pkg::*;
(
    input  wire vscfg_strap_s tie_plan, // rail chosen per pin
    output vscfg_strap_s      pins      // levels seen by the device
);
    // a tie is a static level, so no glitch or float reaches the device
    assign pins = tie_plan;
endmodule

// File: sim/video_switch_config_regs_bench.sv
`timescale 1ns/1ps
module video_switch_config_regs_bench
    import vscfg_pkg::*;
;
    localparam int PCYC = 20;           // short pulse keeps the run brief
    logic         ref_clk   = 1'b0;     // 40 MHz
    logic         reset     = 1'b1;     // held at start
    logic         reg_wr    = 1'b0;     // write strobe
    logic         reg_rd    = 1'b0;     // read strobe
    logic [7:0]   reg_addr  = 8'h00;    // offset
    logic [7:0]   reg_wdata = 8'h00;    // write data
    logic [7:0]   reg_rdata;            // read data
    logic         reg_rvalid;           // read valid
    logic         parallel_mode;        // straps in control
    vscfg_cfg_s   cfg_out;              // applied config
    vscfg_strap_s tie_plan  = '0;       // board ties
    vscfg_strap_s strap_pins;           // pins at device
    int           err_count = 0;        // mismatches
    int           checks    = 0;        // comparisons
    logic [31:0]  seed      = 32'h62EB; // xorshift state
    logic [7:0]   m [logic [7:0]];      // register model
    logic [7:0]   mk [logic [7:0]];     // writable masks
    logic [1:0]   hs_route;             // applied high speed route
    logic [1:0]   aux_route;            // applied aux route
    logic         pulsing   = 1'b0;     // pulse window open
    logic [7:0]   al [9] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20, 8'h05};
    logic [7:0]   d;                    // scratch byte
    logic [1:0]   sel;                  // strap route

    vscfg_strap_board i_vscfg_strap_board (.tie_plan(tie_plan), .pins(strap_pins));
    vscfg_regs #(.PULSE_CYC(PCYC)) i_vscfg_regs (.ref_clk(ref_clk), .reset(reset),
        .strap_pins(strap_pins), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .parallel_mode(parallel_mode), .cfg_out(cfg_out));

    // clock
    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // expected config from the model registers
    function vscfg_cfg_s exp_cfg();
        vscfg_cfg_s c;
        c.highspeed_enable     = m[8'h00][6];
        c.highspeed_source_sel = hs_route;
        c.aux_enable           = m[8'h01][6];
        c.aux_source_sel       = aux_route;
        c.input_term_connect   = !m[8'h10][0] ? 12'h000 :
                                 pulsing ? ~{m[8'h12][3:0], m[8'h11]} : 12'hFFF;
        c.equalization_bits    = {m[8'h14][3:0], m[8'h13]};
        c.preemphasis_level    = m[8'h20][3:2];
        c.output_term_enable   = m[8'h20][1];
        c.output_current_level = m[8'h20][0];
        return c;
    endfunction

    task automatic chk_b(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_c();
        vscfg_cfg_s e;
        e = exp_cfg();
        checks++;
        if (cfg_out !== e)
        begin
            err_count++;
            $display("[FAIL] cfg_out expected %h seen %h", e, cfg_out);
        end
    endtask

    // write: strobe held up to the taking edge, model follows
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        if (m.exists(a))
            m[a] = v & mk[a];
        // illegal code 11 never moves a route
        if (a == 8'h00 && v[1:0] != 2'h3 && v[1:0] != hs_route)
        begin
            hs_route = v[1:0];
            pulsing  = 1'b1;
        end
        if (a == 8'h01 && v[1:0] != 2'h3)
            aux_route = v[1:0];
    endtask

    // read and compare; unmapped offsets read zero
    // rvalid stands only for the cycle after the taking edge, so look then
    task automatic rdc(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk_b("rvalid", 8'h01, {7'h0, reg_rvalid});
        chk_b("rdata", m.exists(a) ? m[a] : 8'h00, reg_rdata);
    endtask

    task automatic end_sim();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog, far beyond the 170 or so cycles needed
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        err_count++;
        end_sim();
    end

    initial
    begin
        seed = xs(seed);
        sel  = seed[9:8] == 2'h3 ? 2'h1 : seed[9:8];
        tie_plan = {seed[0], sel, seed[1], seed[3:2], seed[4]};
        // strap image the registers should hold
        m[8'h00] = {1'b0, seed[0], 4'h0, sel};
        m[8'h01] = {2'b01, 4'h0, sel};
        m[8'h10] = 8'h01;
        m[8'h11] = 8'h00;
        m[8'h12] = 8'h00;
        m[8'h13] = {8{seed[1]}};
        m[8'h14] = {4'h0, {4{seed[1]}}};
        m[8'h20] = {4'h0, seed[3:2], 1'b1, seed[4]};
        mk = '{8'h00:8'h43, 8'h01:8'h43, 8'h10:8'h01, 8'h11:8'hFF, 8'h12:8'h0F,
               8'h13:8'hFF, 8'h14:8'h0F, 8'h20:8'h0F};
        hs_route  = sel;
        aux_route = sel;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        chk_b("parallel", 8'h01, {7'h0, parallel_mode});
        chk_c();
        rdc(8'h00);
        chk_b("parallel", 8'h00, {7'h0, parallel_mode});
        // random writes everywhere, then read all back
        for (int i = 0; i < 9; i++)
        begin
            seed = xs(seed);
            d    = seed[7:0];
            wr(al[i], d);
        end
        for (int i = 0; i < 9; i++)
            rdc(al[i]);
        repeat (PCYC + 8) @(posedge ref_clk);
        pulsing = 1'b0;
        #1;
        chk_c();
        // source switch with some pulse bits set
        seed = xs(seed);
        wr(8'h10, 8'h01);
        wr(8'h11, seed[7:0] | 8'h01);
        wr(8'h12, seed[15:8]);
        wr(8'h00, {2'b01, 4'h0, hs_route == 2'h2 ? 2'h0 : hs_route + 2'h1});
        repeat (4) @(posedge ref_clk);
        #1;
        chk_c();
        repeat (PCYC + 2) @(posedge ref_clk);
        pulsing = 1'b0;
        #1;
        chk_c();
        // illegal highspeed route code is stored but not applied
        wr(8'h00, 8'h43);
        repeat (4) @(posedge ref_clk);
        #1;
        chk_c();
        rdc(8'h00);
        // every pre-emphasis and aux code
        for (int p = 0; p < 4; p++)
        begin
            seed = xs(seed);
            wr(8'h20, {4'h0, 2'(p), seed[1:0]});
            wr(8'h01, {1'b0, seed[2], 4'h0, 2'(p)});
            wr(8'h10, {7'h0, seed[3]});
            repeat (4) @(posedge ref_clk);
            #1;
            chk_c();
        end
        end_sim();
    end
endmodule
